// ---- logic/epm_top.sv ----
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "epm_cfg.svh"
module epm_top import epm_pkg::*; #(
    parameter int ROW_W = 9,
    parameter int COL_W = 9
) (
    input wire logic clk,                   // Device clock
    input wire logic rst,                   // Async reset, active high
    input wire logic ce,                    // Clock enable
    input wire logic psel,                  // APB select
    input wire logic penable,               // APB enable
    input wire logic pwrite,                // APB write
    input wire logic [11:0] paddr,          // APB byte address
    input wire logic [31:0] pwdata,         // APB write data
    output logic [31:0] prdata,             // APB read data
    output logic pready,                    // APB ready
    output logic pslverr,                   // APB error
    input wire logic charge_move_ctl,       // Charge-move pin, low moves
    input wire logic pixel_clear_ctl,       // Pixel-clear pin, low clears
    input wire logic pause_pin,             // Pause pin
    input wire logic master_sel,            // Mode select pin
    output logic xfer_all_o,                // Global charge move
    output logic clear_all_o,               // Global pixel reset
    output logic reading_o,                 // Readout in progress
    output logic paused_o,                  // Holding after move
    output logic master_o,                  // Master mode active
    output logic [ROW_W-1:0] row_addr_o,    // Row address bus
    output logic row_addr_oe,               // Row bus enable
    output logic [COL_W-1:0] col_addr_o,    // Column address bus
    output logic col_addr_oe                // Column bus enable
);
    // Position register holds 16 bits per axis
    if (ROW_W < 1 || ROW_W > 16 || COL_W < 1 || COL_W > 16) begin : g_bad_width
        $error("epm_top: address widths must be 1 to 16");
    end

    epm_seq_if #(.ROW_W(ROW_W), .COL_W(COL_W)) sif ();

    logic [3:0] pin_raw;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic move_s;
    logic clear_s;
    logic pause_s;
    logic master_s;

    logic ctrl_pause_reg;
    logic [15:0] exp_reg;
    logic [15:0] clr_reg;
    logic [15:0] frame_cnt_reg;
    logic [31:0] rdata_next;
    logic acc_en;
    logic setup_en;
    logic wr_en;
    logic addr_ok;

    assign pin_raw[`EPM_PIN_MOVE] = charge_move_ctl;
    assign pin_raw[`EPM_PIN_CLEAR] = pixel_clear_ctl;
    assign pin_raw[`EPM_PIN_PAUSE] = pause_pin;
    assign pin_raw[`EPM_PIN_MASTER] = master_sel;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    sync1_reg[gi] <= 1'b1;
                    sync2_reg[gi] <= 1'b1;
                end else if (ce) begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    assign move_s = sync2_reg[`EPM_PIN_MOVE];
    assign clear_s = sync2_reg[`EPM_PIN_CLEAR];
    assign pause_s = sync2_reg[`EPM_PIN_PAUSE];
    assign master_s = sync2_reg[`EPM_PIN_MASTER];

    assign sif.master_mode = master_s;
    // Slave exposure comes from the pins
    assign sif.move_n = move_s;
    assign sif.clear_n = clear_s;
    // Setup bit only counts in master mode
    assign sif.pause_blk = pause_s | (master_s & ctrl_pause_reg);
    assign sif.exp_cyc = exp_reg;
    assign sif.clr_cyc = clr_reg;

    epm_seq #(.ROW_W(ROW_W), .COL_W(COL_W)) u_seq (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .sif(sif.seq)
    );

    // Zero wait states keep the master simple
    assign pready = 1'b1;
    assign setup_en = psel && !penable;
    assign acc_en = psel && penable;
    assign addr_ok = (paddr == `EPM_CTRL_OFS) || (paddr == `EPM_STAT_OFS) ||
                     (paddr == `EPM_EXP_OFS) || (paddr == `EPM_CLR_OFS) ||
                     (paddr == `EPM_POS_OFS);
    assign pslverr = acc_en && !addr_ok;
    // Bus writes are frozen with the rest when ce is low
    assign wr_en = acc_en && pwrite && addr_ok && ce;

    // Settings return to defaults on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_pause_reg <= 1'(`EPM_CTRL_RST);
        end else if (wr_en && paddr == `EPM_CTRL_OFS) begin
            ctrl_pause_reg <= pwdata[`EPM_CTRL_PAUSE_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exp_reg <= `EPM_EXP_RST;
        end else if (wr_en && paddr == `EPM_EXP_OFS) begin
            exp_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clr_reg <= `EPM_CLR_RST;
        end else if (wr_en && paddr == `EPM_CLR_OFS) begin
            clr_reg <= pwdata[15:0];
        end
    end

    // Frame count wraps; software reads differences
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_cnt_reg <= 16'h0000;
        end else if (ce && sif.frame_done) begin
            frame_cnt_reg <= frame_cnt_reg + 16'h0001;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            `EPM_CTRL_OFS: rdata_next[`EPM_CTRL_PAUSE_BIT] = ctrl_pause_reg;
            `EPM_STAT_OFS: rdata_next = {frame_cnt_reg, 8'h00, master_s, sif.pause_blk, 1'b0, sif.state};
            `EPM_EXP_OFS: rdata_next[15:0] = exp_reg;
            `EPM_CLR_OFS: rdata_next[15:0] = clr_reg;
            `EPM_POS_OFS: rdata_next = {16'(sif.row), 16'(sif.col)};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data captured in setup, valid through access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_en && !pwrite) begin
            prdata <= rdata_next;
        end
    end

    // Single global controls for the whole array
    assign xfer_all_o = sif.xfer_all;
    assign clear_all_o = sif.clr_all;
    assign reading_o = (sif.state == read_state);
    assign paused_o = (sif.state == storage_hold_state) && sif.pause_blk;

    // Address buses driven in master mode only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            master_o <= 1'b0;
            row_addr_oe <= 1'b0;
            col_addr_oe <= 1'b0;
        end else if (ce) begin
            master_o <= master_s;
            row_addr_oe <= master_s;
            col_addr_oe <= master_s;
        end
    end

    assign row_addr_o = sif.row;
    assign col_addr_o = sif.col;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_slave_move;
        (ce && !master_s && !master_o && !sif.state[4] && !move_s) |=> xfer_all_o;
    endproperty
    a_slave_move: assert property (p_slave_move) else $error("slave charge move not applied");

    property p_slave_keep;
        (ce && !master_s && move_s && $past(!master_s)) |=> !xfer_all_o;
    endproperty
    a_slave_keep: assert property (p_slave_keep) else $error("storage not kept with move high");

    property p_slave_clear;
        (ce && !master_s && !master_o) |=> (clear_all_o == !$past(clear_s));
    endproperty
    a_slave_clear: assert property (p_slave_clear) else $error("pixel clear does not follow pin");

    property p_global;
        (master_o && xfer_all_o) |-> !reading_o && !clear_all_o;
    endproperty
    a_global: assert property (p_global) else $error("global move overlaps read or clear");

    property p_reset;
        @(posedge clk) disable iff (1'b0)
        rst |-> (!ctrl_pause_reg && exp_reg == `EPM_EXP_RST && sif.state == pixel_clear_state);
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not restore defaults");

    property p_pause_hold;
        (sif.state == storage_hold_state && sif.pause_blk && master_s == master_o) |=> !reading_o;
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("readout began while paused");

    property p_no_pause;
        (ce && sif.state == storage_hold_state && !sif.pause_blk && master_s == master_o) |=> reading_o;
    endproperty
    a_no_pause: assert property (p_no_pause) else $error("readout did not follow unpaused move");

    property p_master_bit;
        (master_s && ctrl_pause_reg && sif.state == storage_hold_state) |=> !reading_o;
    endproperty
    a_master_bit: assert property (p_master_bit) else $error("setup pause bit ignored");

    property p_mode_change;
        (ce && master_s != master_o) |=> (sif.state == pixel_clear_state);
    endproperty
    a_mode_change: assert property (p_mode_change) else $error("mode change did not restart");

    property p_addr_bus;
        master_o |-> (row_addr_oe && col_addr_oe && row_addr_o == sif.row && col_addr_o == sif.col);
    endproperty
    a_addr_bus: assert property (p_addr_bus) else $error("address bus not driven in master");

    property p_sync;
        (ce && !$past(rst) ##1 ce) |=> (master_s == $past(master_sel, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("mode pin not two-stage synchronised");
endmodule
`default_nettype wire

// ---- include/epm_cfg.svh ----
`ifndef EPM_CFG_SVH
`define EPM_CFG_SVH
// APB register byte offsets
`define EPM_CTRL_OFS 12'h000
`define EPM_STAT_OFS 12'h004
`define EPM_EXP_OFS 12'h008
`define EPM_CLR_OFS 12'h00c
`define EPM_POS_OFS 12'h010
// Control register fields
`define EPM_CTRL_PAUSE_BIT 0
`define EPM_CTRL_RST 32'h0000_0000
// Timer reset values, in clock cycles
`define EPM_EXP_RST 16'h0100
`define EPM_CLR_RST 16'h0010
// Length of a master-mode charge move, in cycles
`define EPM_MOVE_CYC 16'h0004
// Pin sync vector positions
`define EPM_PIN_MOVE 0
`define EPM_PIN_CLEAR 1
`define EPM_PIN_PAUSE 2
`define EPM_PIN_MASTER 3
`endif

// ---- include/epm_pkg.sv ----
package epm_pkg;
    typedef enum logic [4:0] {
        pixel_clear_state = 5'b00001,
        integrate_state = 5'b00010,
        move_to_storage_state = 5'b00100,
        storage_hold_state = 5'b01000,
        read_state = 5'b10000
    } epm_state_t;
endpackage

// ---- include/epm_seq_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface epm_seq_if #(parameter int ROW_W = 9, parameter int COL_W = 9) ();
    import epm_pkg::*;
    logic master_mode;
    logic move_n;
    logic clear_n;
    logic pause_blk;
    logic [15:0] exp_cyc;
    logic [15:0] clr_cyc;
    epm_state_t state;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic xfer_all;
    logic clr_all;
    logic frame_done;
    modport top (output master_mode, move_n, clear_n, pause_blk, exp_cyc, clr_cyc,
                 input state, row, col, xfer_all, clr_all, frame_done);
    modport seq (input master_mode, move_n, clear_n, pause_blk, exp_cyc, clr_cyc,
                 output state, row, col, xfer_all, clr_all, frame_done);
endinterface
`default_nettype wire

// ---- logic/epm_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "epm_cfg.svh"
module epm_seq import epm_pkg::*; #(
    parameter int ROW_W = 9,
    parameter int COL_W = 9
) (
    input wire logic clk,  // Device clock
    input wire logic rst,  // Async reset
    input wire logic ce,   // Clock enable
    epm_seq_if.seq sif     // Control and status
);
    epm_state_t state_reg;
    epm_state_t state_next;
    logic mode_reg;
    logic [15:0] cnt_reg;
    logic [ROW_W-1:0] row_reg;
    logic [COL_W-1:0] col_reg;
    logic last_pix;

    assign last_pix = (row_reg == {ROW_W{1'b1}}) && (col_reg == {COL_W{1'b1}});

    always_comb begin
        state_next = state_reg;
        if (sif.master_mode != mode_reg) begin
            state_next = pixel_clear_state;
        end else if (mode_reg) begin
            case (state_reg)
                pixel_clear_state: if (cnt_reg >= sif.clr_cyc) state_next = integrate_state;
                integrate_state: if (cnt_reg >= sif.exp_cyc) state_next = move_to_storage_state;
                move_to_storage_state: if (cnt_reg >= `EPM_MOVE_CYC - 16'h0001) state_next = storage_hold_state;
                storage_hold_state: if (!sif.pause_blk) state_next = read_state;
                read_state: if (last_pix) state_next = pixel_clear_state;
                default: state_next = pixel_clear_state;
            endcase
        end else begin
            case (state_reg)
                move_to_storage_state: if (sif.move_n) state_next = storage_hold_state;
                // Pause decides hold or straight readout
                storage_hold_state: if (!sif.pause_blk) state_next = read_state;
                read_state: if (last_pix) state_next = sif.clear_n ? integrate_state : pixel_clear_state;
                pixel_clear_state, integrate_state: begin
                    if (!sif.move_n) state_next = move_to_storage_state;
                    else state_next = sif.clear_n ? integrate_state : pixel_clear_state;
                end
                default: state_next = pixel_clear_state;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= pixel_clear_state;
            mode_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            mode_reg <= sif.master_mode;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
        end else if (ce) begin
            cnt_reg <= (state_next != state_reg) ? 16'h0000 : cnt_reg + 16'h0001;
        end
    end

    // Column fastest, row on column wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            row_reg <= '0;
            col_reg <= '0;
        end else if (ce) begin
            if (state_reg != read_state) begin
                row_reg <= '0;
                col_reg <= '0;
            end else begin
                col_reg <= col_reg + 1'b1;
                if (col_reg == {COL_W{1'b1}}) row_reg <= row_reg + 1'b1;
            end
        end
    end

    // Global charge move, global pixel clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sif.xfer_all <= 1'b0;
            sif.clr_all <= 1'b1;
            sif.frame_done <= 1'b0;
        end else if (ce) begin
            sif.xfer_all <= mode_reg ? (state_next == move_to_storage_state) : !sif.move_n;
            sif.clr_all <= mode_reg ? (state_next == pixel_clear_state) : !sif.clear_n;
            sif.frame_done <= (state_reg == read_state) && last_pix;
        end
    end

    assign sif.state = state_reg;
    assign sif.row = row_reg;
    assign sif.col = col_reg;

    property p_move_len;
        @(posedge clk) disable iff (rst)
        (ce && mode_reg && sif.master_mode && $changed(state_reg) && state_reg == move_to_storage_state)
            |-> (state_reg == move_to_storage_state) [*4];
    endproperty
    a_move_len: assert property (p_move_len) else $error("master charge move too short");
endmodule
`default_nettype wire

// ---- dv/epm_cam_ctl.sv ----
`timescale 1ns/1ps
`default_nettype none
module epm_cam_ctl (
    input wire logic clk,          // Controller clock
    input wire logic rst,          // Async reset, active high
    input wire logic [3:0] cmd,    // Requested {mode, pause, clear, move} levels
    output logic charge_move_ctl,  // Charge-move pin, low moves
    output logic pixel_clear_ctl,  // Pixel-clear pin, low clears
    output logic pause_pin,        // Pause pin
    output logic master_sel        // Mode select pin
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charge_move_ctl <= 1'b1;
            pixel_clear_ctl <= 1'b1;
        end else begin
            charge_move_ctl <= cmd[0];
            pixel_clear_ctl <= cmd[1];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pause_pin <= 1'b0;
            master_sel <= 1'b0;
        end else begin
            pause_pin <= cmd[2];
            master_sel <= cmd[3];
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb_exposure_pause_mode_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "epm_cfg.svh"
module tb_exposure_pause_mode_control;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, v;
    logic mv, pc, pp, ms, xfer, clr, reading, paused, mstr, roe, coe;
    logic [1:0] row, col;
    logic [3:0] cmd, a0;
    int n_fail, num_checks, cyc;

    epm_top #(.ROW_W(2), .COL_W(2)) DUT (
        .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .charge_move_ctl(mv), .pixel_clear_ctl(pc), .pause_pin(pp), .master_sel(ms),
        .xfer_all_o(xfer), .clear_all_o(clr), .reading_o(reading), .paused_o(paused),
        .master_o(mstr), .row_addr_o(row), .row_addr_oe(roe), .col_addr_o(col), .col_addr_oe(coe)
    );
    epm_cam_ctl cam (
        .clk(clk), .rst(rst), .cmd(cmd), .charge_move_ctl(mv), .pixel_clear_ctl(pc),
        .pause_pin(pp), .master_sel(ms)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [3:0] addr_after(input logic [3:0] a);
        return a + 4'h1;
    endfunction
    function automatic logic sig_of(input int w);
        return (w == 0) ? reading : paused;
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Each transfer ends one idle edge later, so back-to-back calls never clash
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pins(input logic [3:0] c, input int n);
        cmd <= c;
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_on(input int w, input logic val, input int lim);
        int n = 0;
        while (sig_of(w) !== val && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk("wait", 32'(sig_of(w)), 32'(val));
    endtask
    task automatic chk_defaults();
        apb(1'b0, `EPM_CTRL_OFS, 32'h0);
        chk("ctrl", rd, `EPM_CTRL_RST);
        apb(1'b0, `EPM_EXP_OFS, 32'h0);
        chk("exp", rd, 32'(`EPM_EXP_RST));
        apb(1'b0, `EPM_CLR_OFS, 32'h0);
        chk("clr", rd, 32'(`EPM_CLR_RST));
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cmd = 4'b0011;
        seed = 32'h3d2b;
        repeat (4) @(posedge clk);
        chk("clear_rst", 32'(clr), 32'h1);
        chk("master_rst", 32'({mstr, roe, coe, xfer, reading}), 32'h0);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        chk_defaults();
        seed = xs(seed);
        apb(1'b1, 12'h020, seed);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        // Pin must not reach the output before its sync delay
        pins(4'b0001, 2);
        chk("clear_sync", 32'(clr), 32'h0);
        pins(4'b0001, 6);
        chk("clear_low", 32'(clr), 32'h1);
        pins(4'b0111, 6);
        chk("clear_high", 32'(clr), 32'h0);
        pins(4'b0110, 6);
        chk("move_low", 32'(xfer), 32'h1);
        pins(4'b0111, 6);
        chk("move_high", 32'(xfer), 32'h0);
        chk("slave_pause", 32'(paused), 32'h1);
        repeat (30) @(posedge clk);
        chk("slave_noread", 32'(reading), 32'h0);
        pins(4'b0011, 0);
        wait_on(0, 1'b1, 12);
        chk("slave_oe", 32'({roe, coe}), 32'h0);
        wait_on(0, 1'b0, 40);
        pins(4'b1011, 8);
        chk("master", 32'({mstr, roe, coe}), 32'h7);
        for (int k = 0; k < 2; k++) begin
            seed = xs(seed);
            v = {28'h0, seed[3:0]} + 32'h1;
            apb(1'b1, k ? `EPM_CLR_OFS : `EPM_EXP_OFS, v);
            apb(1'b0, k ? `EPM_CLR_OFS : `EPM_EXP_OFS, 32'h0);
            chk("timer", rd, v);
        end
        // Setup bit alone, then pin alone, must each block readout
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `EPM_CTRL_OFS, 32'(k == 0));
            pins((k == 0) ? 4'b1011 : 4'b1111, 0);
            wait_on(1, 1'b1, 200);
            repeat (20) @(posedge clk);
            chk("master_noread", 32'(reading), 32'h0);
            apb(1'b0, `EPM_STAT_OFS, 32'h0);
            chk("status", 32'({rd[7], rd[4:0]}), 32'h28);
            apb(1'b1, `EPM_CTRL_OFS, 32'h0);
            pins(4'b1011, 0);
            wait_on(0, 1'b1, 12);
            a0 = {row, col};
            chk("addr0", 32'(a0), 32'h0);
            for (int j = 0; j < 8; j++) begin
                @(posedge clk);
                chk("addr", 32'({row, col}), 32'(addr_after(a0)));
                a0 = {row, col};
            end
        end
        // Reset in the middle of a master readout
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("mid_rst", 32'({clr, mstr, roe, coe, xfer, reading, paused}), 32'h40);
        rst <= 1'b0;
        pins(4'b0011, 10);
        chk_defaults();
        complete_run();
    end
endmodule
`default_nettype wire
